// ==== core/acq_pkg.sv ====
// Purpose: shared types and constants of the acquisition trigger sequencer
// Assumes: pclk at 250 MHz, APB register access, 32-bit data
// Notes: offsets are byte addresses; counts derive from times in ns
package acq_pkg;
  localparam int CLK_NS  = 4;
  localparam int BASE_NS = 5000;
  localparam int BASE_CYC = (BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [10:0] BASE_LAST = 11'(BASE_CYC - 1);
  localparam int DEPTH   = 512;
  localparam int AW      = 9;
  localparam int PORT_W  = 8;
  localparam int NPORT   = 3;
  localparam int NCTR    = 4;
  localparam int CI_LSB  = 2;
  localparam logic [15:0] CTR_MAX   = 16'hffff;
  localparam logic [15:0] PAT8_MASK = 16'hff00;
  localparam logic [31:0] PACER_RST = 32'h0000_0001;
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_CMD    = 8'h04;
  localparam logic [7:0] A_STAT   = 8'h08;
  localparam logic [7:0] A_PACER  = 8'h0c;
  localparam logic [7:0] A_SEQLEN = 8'h10;
  localparam logic [7:0] A_SEQADR = 8'h14;
  localparam logic [7:0] A_SEQDAT = 8'h18;
  localparam logic [7:0] A_TCH    = 8'h1c;
  localparam logic [7:0] A_ALVL   = 8'h20;
  localparam logic [7:0] A_HWLVL  = 8'h24;
  localparam logic [7:0] A_PAT    = 8'h28;
  localparam logic [7:0] A_PMASK  = 8'h2c;
  localparam logic [7:0] A_CLVL   = 8'h30;
  localparam logic [7:0] A_CSEL   = 8'h34;
  localparam logic [7:0] A_DIO    = 8'h38;
  localparam logic [7:0] A_CTR0   = 8'h40;
  localparam logic [7:0] A_CTRMSK = 8'h0c;

  typedef enum logic [1:0] {S_IDLE = 2'h0, S_ARM = 2'h1, S_RUN = 2'h3, S_DONE = 2'h2} state_e;
  typedef enum logic [2:0] {T_NONE = 3'h0, T_HWANA = 3'h1, T_SWANA = 3'h2, T_DIG = 3'h3,
                            T_PAT = 3'h4, T_CTR = 3'h5, T_SOFT = 3'h6, T_RSV = 3'h7} src_e;
  typedef enum logic [2:0] {C_EQ = 3'h0, C_ABOVE = 3'h1, C_BELOW = 3'h2, C_IN = 3'h3,
                            C_OUT = 3'h4, C_R5 = 3'h5, C_R6 = 3'h6, C_R7 = 3'h7} cmp_e;
  typedef enum logic [1:0] {K_ANA = 2'h0, K_DIG = 2'h1, K_CTR = 2'h2, K_RSV = 2'h3} kind_e;

  typedef struct packed {
    kind_e       kind;
    logic        bip;
    logic [2:0]  gain;
    logic [4:0]  chan;
  } entry_s;
  localparam int ENT_W = $bits(entry_s);

  typedef struct packed {
    logic [5:0]  rsv;
    logic [2:0]  port_dir;
    logic [3:0]  clr_rd;
    logic [1:0]  cascade;
    logic        pat16;
    cmp_e        stop_cmp;
    cmp_e        start_cmp;
    logic        pre_var;
    logic        pre_en;
    src_e        stop_src;
    src_e        start_src;
    logic        rate10;
    logic        ext_clk;
  } ctrl_s;

  typedef struct packed {
    logic        valid;
    logic        pre;
    logic [8:0]  idx;
    entry_s      ent;
    logic [15:0] data;
  } scan_s;

  function automatic logic cmp_hit(input logic [15:0] v, input logic [15:0] lo,
                                   input logic [15:0] hi, input cmp_e m);
    case (m)
      C_EQ:    cmp_hit = (v == lo);
      C_ABOVE: cmp_hit = (v > lo);
      C_BELOW: cmp_hit = (v < lo);
      C_IN:    cmp_hit = (v >= lo) && (v <= hi);
      C_OUT:   cmp_hit = (v < lo) || (v > hi);
      default: cmp_hit = 1'b0;
    endcase
  endfunction : cmp_hit
endpackage : acq_pkg

// ==== core/acq_trigger_sequencer.sv ====
// Purpose: scan sequencer, start/stop triggering, counters and digital ports
// Assumes: all inputs synchronous to pclk; APB slave with no wait states
// Notes: one scan runs all entries; ticks arriving mid-scan are dropped
//
// Behaviour
// - Scan clock comes from internal pacer or external TTL input to 200 kHz.
// - Pacer period is set in 5 us steps up to about 5.96 hours.
// - Up to 512 entries, each with its own channel, gain and polarity.
// - Entries within a scan are spaced 5 us or 10 us apart; on the external clock entry 1 comes at the next channel slot.
// - Six trigger sources, chosen separately for start and for stop.
// - Stop may watch another channel; only sources 2, 4, 5, 6 may stop.
// - Pre-trigger scans are kept, with fixed or variable length.
// - Hardware analog trigger uses 11-bit level and hysteresis, fires fast.
// - Software analog trigger compares a 16-bit level or window per scan.
// - Digital trigger input acts within 5 us; levels last at least 50 ns.
// - Pattern trigger on 8 or 16 port bits with five compare modes.
// - Any pattern bit can be masked out of the compare.
// - Counter trigger compares frequency or total count, five modes.
// - A software command starts acquisition directly.
// - Four 16-bit counters, pairable into two 32-bit counters.
// - Each counter clears on read or accumulates until cleared.
// - Counter values can be sampled as scan entries on the scan clock.
// - Three 8-bit ports, each set as input or output.
// - Ports readable at any time or sampled within a scan.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module acq_trigger_sequencer (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 ext_scan_clock_in,
  input  wire logic                 dig_trig_in,
  input  wire logic [10:0]          hw_mon,
  output logic      [4:0]           mon_chan,
  input  wire logic                 adc_valid,
  input  wire logic [4:0]           adc_chan,
  input  wire logic [15:0]          adc_data,
  input  wire logic [3:0]           cnt_in,
  input  wire logic [23:0]          dio_in,
  output logic      [23:0]          dio_out,
  output logic      [23:0]          dio_oe_n,
  output acq_pkg::scan_s            scan,
  output logic                      running
);
  typedef struct packed {
    acq_pkg::state_e  fsm;
    acq_pkg::ctrl_s   ctrl;
    logic [31:0]      pacer;
    logic [8:0]       last;
    logic [15:0]      pre_n;
    logic [8:0]       wadr;
    logic [4:0]       ch_st;
    logic [4:0]       ch_sp;
    logic [31:0]      alvl;
    logic [10:0]      hw_lvl;
    logic [10:0]      hw_hys;
    logic [31:0]      pat;
    logic [15:0]      pmask;
    logic [31:0]      clvl;
    logic [1:0]       csel;
    logic             cfreq;
    logic [23:0]      dout;
    logic [23:0]      oe_n;
    logic [3:0][15:0] ctr;
    logic [3:0][15:0] fcnt;
    logic [3:0][15:0] frq;
    logic [3:0][15:0] csnap;
    logic [3:0]       cin_d;
    logic [23:0]      dsnap;
    logic [10:0]      base;
    logic [31:0]      pcnt;
    logic             ext_d;
    logic             dtr_d;
    logic             hw_arm;
    logic             f_start;
    logic             f_stop;
    logic             busy;
    logic             half;
    logic             swt;
    logic [15:0]      pre_cnt;
    logic [8:0]       idx;
    logic [4:0]       mon;
    logic             run;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    acq_pkg::scan_s   scan;
  } st_s;

  st_s             q;
  st_s             d;
  acq_pkg::entry_s seq_mem [acq_pkg::DEPTH];

  logic            setup, acc, wr, rd, base_tick, int_tick, ext_rise, scan_tick;
  logic            scanning, scan_go, ch_tick, step, hw_fire, dtr_rise, pre_ok;
  logic            stop_ok, start_ev, stop_ev;
  logic [8:0]      eidx;
  logic [15:0]     pmask_eff, pv, ctr_v;
  acq_pkg::entry_s ent;

  assign setup     = psel && !penable;
  assign acc       = psel && penable && q.pready;
  assign wr        = acc && pwrite;
  assign rd        = acc && !pwrite;
  assign base_tick = (q.base == acq_pkg::BASE_LAST);
  // Period 0 behaves as 1 so the pacer can never stall
  assign int_tick  = base_tick && (q.pcnt + 32'h1 >= q.pacer);
  assign ext_rise  = ext_scan_clock_in && !q.ext_d;
  assign scan_tick = q.ctrl.ext_clk ? ext_rise : int_tick;
  assign scanning  = (q.fsm == acq_pkg::S_RUN) || (q.fsm == acq_pkg::S_ARM && q.ctrl.pre_en);
  assign scan_go   = scan_tick && scanning && !q.busy;
  assign ch_tick   = base_tick && (!q.ctrl.rate10 || q.half);
  assign step      = q.busy && ch_tick && scanning;
  assign eidx      = scan_go ? '0 : q.idx + 9'h1;
  assign ent       = seq_mem[eidx];
  assign hw_fire   = q.hw_arm && (hw_mon >= q.hw_lvl);
  assign dtr_rise  = dig_trig_in && !q.dtr_d;
  assign pmask_eff = q.pmask | (q.ctrl.pat16 ? '0 : acq_pkg::PAT8_MASK);
  assign pv        = dio_in[15:0] & ~pmask_eff;
  assign ctr_v     = q.cfreq ? q.frq[q.csel] : q.ctr[q.csel];
  assign pre_ok    = !q.ctrl.pre_en || q.ctrl.pre_var || (q.pre_cnt >= q.pre_n);
  assign stop_ok   = q.ctrl.stop_src inside {acq_pkg::T_SWANA, acq_pkg::T_PAT,
                                             acq_pkg::T_CTR, acq_pkg::T_SOFT};

  // Same source decode serves start and stop; each has its own channel and mode
  function automatic logic fire(input acq_pkg::src_e s, input acq_pkg::cmp_e c, input logic [4:0] ch);
    case (s)
      acq_pkg::T_HWANA: fire = hw_fire;
      acq_pkg::T_SWANA: fire = adc_valid && (adc_chan == ch) &&
                               acq_pkg::cmp_hit(adc_data, q.alvl[15:0], q.alvl[31:16], c);
      acq_pkg::T_DIG:   fire = dtr_rise;
      acq_pkg::T_PAT:   fire = scan_tick && acq_pkg::cmp_hit(pv, q.pat[15:0] & ~pmask_eff,
                                                          q.pat[31:16] & ~pmask_eff, c);
      acq_pkg::T_CTR:   fire = scan_tick && acq_pkg::cmp_hit(ctr_v, q.clvl[15:0], q.clvl[31:16], c);
      acq_pkg::T_SOFT:  fire = q.swt;
      default:          fire = 1'b0;
    endcase
  endfunction : fire

  assign start_ev = fire(q.ctrl.start_src, q.ctrl.start_cmp, q.ch_st);
  assign stop_ev  = stop_ok && fire(q.ctrl.stop_src, q.ctrl.stop_cmp, q.ch_sp);

  function automatic logic [7:0] port_of(input logic [23:0] v, input logic [1:0] p);
    port_of = (p < 2'(acq_pkg::NPORT)) ? v[p*acq_pkg::PORT_W +: acq_pkg::PORT_W] : '0;
  endfunction : port_of

  always_ff @(posedge pclk) begin
    if (wr && paddr == acq_pkg::A_SEQDAT) begin
      seq_mem[q.wadr] <= acq_pkg::entry_s'(pwdata[acq_pkg::ENT_W-1:0]);
    end
  end

  always_comb begin
    logic [3:0] inc;
    logic [3:0] edg;
    logic [3:0] clr;
    logic [1:0] ci;
    d          = q;
    inc        = '0;
    edg        = cnt_in & ~q.cin_d;
    clr        = '0;
    ci         = paddr[acq_pkg::CI_LSB +: 2];
    d.pready   = setup;
    d.pslverr  = 1'b0;
    d.ext_d    = ext_scan_clock_in;
    d.dtr_d    = dig_trig_in;
    d.cin_d    = cnt_in;
    d.swt      = 1'b0;
    d.scan.valid = 1'b0;
    // Read data is prepared in setup so that prdata comes from a flop
    if (setup) begin
      d.prdata = '0;
      case (paddr)
        acq_pkg::A_CTRL:   d.prdata = q.ctrl;
        acq_pkg::A_CMD:    d.prdata = '0;
        acq_pkg::A_STAT:   d.prdata = {27'h0, q.busy, q.fsm, q.f_stop, q.f_start};
        acq_pkg::A_PACER:  d.prdata = q.pacer;
        acq_pkg::A_SEQLEN: d.prdata = {q.pre_n, 7'h0, q.last};
        acq_pkg::A_SEQADR: d.prdata = {23'h0, q.wadr};
        acq_pkg::A_SEQDAT: d.prdata = {21'h0, seq_mem[q.wadr]};
        acq_pkg::A_TCH:    d.prdata = {19'h0, q.ch_sp, 3'h0, q.ch_st};
        acq_pkg::A_ALVL:   d.prdata = q.alvl;
        acq_pkg::A_HWLVL:  d.prdata = {5'h0, q.hw_hys, 5'h0, q.hw_lvl};
        acq_pkg::A_PAT:    d.prdata = q.pat;
        acq_pkg::A_PMASK:  d.prdata = {16'h0, q.pmask};
        acq_pkg::A_CLVL:   d.prdata = q.clvl;
        acq_pkg::A_CSEL:   d.prdata = {29'h0, q.cfreq, q.csel};
        acq_pkg::A_DIO:    d.prdata = {8'h0, dio_in};
        default: begin
          if ((paddr & ~acq_pkg::A_CTRMSK) == acq_pkg::A_CTR0) begin
            d.prdata = {16'h0, q.ctr[ci]};
          end else begin
            d.pslverr = 1'b1;
          end
        end
      endcase
    end
    if (rd && (paddr & ~acq_pkg::A_CTRMSK) == acq_pkg::A_CTR0) begin
      clr[ci] = q.ctrl.clr_rd[ci];
    end
    if (wr) begin
      case (paddr)
        acq_pkg::A_CTRL:   d.ctrl = acq_pkg::ctrl_s'(pwdata);
        acq_pkg::A_CMD: begin
          if (pwdata[0] && q.fsm == acq_pkg::S_IDLE) begin
            d.fsm     = acq_pkg::S_ARM;
            d.pre_cnt = '0;
            d.hw_arm  = 1'b0;
          end
          d.swt = pwdata[1];
          clr   = clr | pwdata[5:2];
        end
        acq_pkg::A_STAT: begin
          d.f_start = q.f_start & ~pwdata[0];
          d.f_stop  = q.f_stop & ~pwdata[1];
        end
        acq_pkg::A_PACER:  d.pacer = pwdata;
        acq_pkg::A_SEQLEN: begin
          d.last  = pwdata[8:0];
          d.pre_n = pwdata[31:16];
        end
        acq_pkg::A_SEQADR: d.wadr = pwdata[8:0];
        acq_pkg::A_SEQDAT: d.wadr = q.wadr + 9'h1;
        acq_pkg::A_TCH: begin
          d.ch_st = pwdata[4:0];
          d.ch_sp = pwdata[12:8];
        end
        acq_pkg::A_ALVL:   d.alvl = pwdata;
        acq_pkg::A_HWLVL: begin
          d.hw_lvl = pwdata[10:0];
          d.hw_hys = pwdata[26:16];
        end
        acq_pkg::A_PAT:    d.pat = pwdata;
        acq_pkg::A_PMASK:  d.pmask = pwdata[15:0];
        acq_pkg::A_CLVL:   d.clvl = pwdata;
        acq_pkg::A_CSEL: begin
          d.csel  = pwdata[1:0];
          d.cfreq = pwdata[2];
        end
        acq_pkg::A_DIO:    d.dout = pwdata[23:0];
        default: ;
      endcase
    end
    for (int p = 0; p < acq_pkg::NPORT; p++) begin
      d.oe_n[p*acq_pkg::PORT_W +: acq_pkg::PORT_W] = {acq_pkg::PORT_W{!q.ctrl.port_dir[p]}};
    end
    // Counters; an odd counter takes its carry from the even one when paired
    for (int i = 0; i < acq_pkg::NCTR; i++) begin
      if (i % 2 == 1 && q.ctrl.cascade[i/2]) begin
        inc[i] = inc[i-1] && (q.ctr[i-1] == acq_pkg::CTR_MAX);
      end else begin
        inc[i] = edg[i];
      end
      d.ctr[i] = clr[i] ? {15'h0, inc[i]} : q.ctr[i] + {15'h0, inc[i]};
      if (scan_tick) begin
        d.frq[i]  = q.fcnt[i];
        d.fcnt[i] = {15'h0, edg[i]};
      end else begin
        d.fcnt[i] = q.fcnt[i] + {15'h0, edg[i]};
      end
    end
    d.base = base_tick ? '0 : q.base + 11'h1;
    if (base_tick) begin
      d.pcnt = int_tick ? '0 : q.pcnt + 32'h1;
      d.half = !q.half;
    end
    // Re-arm only once the input falls below level minus hysteresis
    if ({1'b0, hw_mon} + {1'b0, q.hw_hys} < {1'b0, q.hw_lvl}) begin
      d.hw_arm = 1'b1;
    end else if (hw_fire) begin
      d.hw_arm = 1'b0;
    end
    if (scan_go) begin
      d.dsnap = dio_in;
      d.csnap = q.ctr;
      d.half  = 1'b0;
      if (q.fsm == acq_pkg::S_ARM && q.pre_cnt != acq_pkg::CTR_MAX) begin
        d.pre_cnt = q.pre_cnt + 16'h1;
      end
    end
    if (scan_go || step) begin
      d.idx        = eidx;
      d.busy       = (eidx != q.last);
      d.scan.valid = 1'b1;
      d.scan.pre   = (q.fsm == acq_pkg::S_ARM);
      d.scan.idx   = eidx;
      d.scan.ent   = ent;
      unique case (ent.kind)
        acq_pkg::K_DIG: d.scan.data = {8'h0, port_of(scan_go ? dio_in : q.dsnap, ent.chan[1:0])};
        acq_pkg::K_CTR: d.scan.data = scan_go ? q.ctr[ent.chan[1:0]] : q.csnap[ent.chan[1:0]];
        acq_pkg::K_ANA, acq_pkg::K_RSV: d.scan.data = '0;
      endcase
    end
    unique case (q.fsm)
      acq_pkg::S_IDLE: ;
      acq_pkg::S_ARM: begin
        if (start_ev && pre_ok) begin
          d.fsm     = acq_pkg::S_RUN;
          d.f_start = 1'b1;
        end
      end
      acq_pkg::S_RUN: begin
        if (stop_ev) begin
          d.fsm    = acq_pkg::S_DONE;
          d.f_stop = 1'b1;
        end
      end
      acq_pkg::S_DONE: begin
        d.fsm  = acq_pkg::S_IDLE;
        d.busy = 1'b0;
      end
    endcase
    d.mon = (d.fsm == acq_pkg::S_RUN) ? q.ch_sp : q.ch_st;
    d.run = (d.fsm == acq_pkg::S_RUN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.pacer <= acq_pkg::PACER_RST;
      q.oe_n  <= '1;
    end else begin
      q <= d;
    end
  end

  assign prdata   = q.prdata;
  assign pready   = q.pready;
  assign pslverr  = q.pslverr;
  assign mon_chan = q.mon;
  assign dio_out  = q.dout;
  assign dio_oe_n = q.oe_n;
  assign scan     = q.scan;
  assign running  = q.run;

  a_start_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == acq_pkg::S_ARM && start_ev && pre_ok) |=> (q.fsm == acq_pkg::S_RUN && q.f_start))
    else $error("start trigger not recognised");
  a_stop_legal: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == acq_pkg::S_RUN && !stop_ok) |=> (q.fsm != acq_pkg::S_DONE))
    else $error("illegal stop source ended run");
  a_soft_start: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == acq_pkg::S_ARM && q.ctrl.start_src == acq_pkg::T_SOFT && q.swt && pre_ok)
    |=> (q.run && q.fsm == acq_pkg::S_RUN))
    else $error("software start ignored");
  a_dig_start: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == acq_pkg::S_ARM && q.ctrl.start_src == acq_pkg::T_DIG && $rose(dig_trig_in) && pre_ok)
    |=> q.fsm == acq_pkg::S_RUN)
    else $error("digital trigger late");
  a_base_period: assert property (@(posedge pclk) disable iff (!presetn)
    base_tick |=> (q.base == 11'h0) ##1 (q.base == 11'h1) ##1 !base_tick)
    else $error("pacer base period wrong");
  a_chan_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (q.scan.valid && q.scan.idx != 9'h0) |-> $past(ch_tick))
    else $error("entry outside channel slot");
  a_scan_first: assert property (@(posedge pclk) disable iff (!presetn)
    scan_go |=> (q.scan.valid && q.scan.idx == 9'h0 && q.busy == (q.last != 9'h0)))
    else $error("scan did not start at entry 0");
  a_ctr_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && (paddr & ~acq_pkg::A_CTRMSK) == acq_pkg::A_CTR0 && q.ctrl.clr_rd[paddr[3:2]] && !cnt_in[paddr[3:2]]
     && paddr[2] == 1'b0) |=> q.ctr[$past(paddr[3:2])] <= 16'h1)
    else $error("clear on read failed");
  a_cascade: assert property (@(posedge pclk) disable iff (!presetn)
    (q.ctrl.cascade[0] && (cnt_in[0] && !q.cin_d[0]) && q.ctr[0] == acq_pkg::CTR_MAX
     && !(wr && paddr == acq_pkg::A_CMD && pwdata[3])
     && !(rd && paddr == acq_pkg::A_CTR0 + 8'h4 && q.ctrl.clr_rd[1]))
    |=> q.ctr[1] == $past(q.ctr[1]) + 16'h1)
    else $error("cascade carry lost");
  a_port_dir: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(q.ctrl.port_dir) |=> (dio_oe_n[0] == !$past(q.ctrl.port_dir[0])
     && dio_oe_n[8] == !$past(q.ctrl.port_dir[1]) && dio_oe_n[16] == !$past(q.ctrl.port_dir[2])))
    else $error("port direction not applied");
endmodule : acq_trigger_sequencer

// ==== verification/acq_far_side.sv ====
// Purpose: far-side model of trigger, clock, counter and port pins
// Assumes: driven from the bench clock domain
// Notes: external scan clock stands still; the bench uses the internal pacer
`timescale 1ns/100ps
module acq_far_side (
  input  wire logic        pclk,
  input  wire logic        fire,
  input  wire logic [23:0] pins,
  output logic             ext_scan_clock_in,
  output logic             dig_trig_in,
  output logic [10:0]      hw_mon,
  output logic             adc_valid,
  output logic [4:0]       adc_chan,
  output logic [15:0]      adc_data,
  output logic [3:0]       cnt_in,
  output logic [23:0]      dio_in
);
  logic [4:0] hold_r = 5'h00;
  logic [1:0] div_r  = 2'h0;
  always_ff @(posedge pclk) begin
    div_r <= div_r + 2'h1;
    if (fire) begin
      hold_r <= 5'h10; // 64 ns high, above the minimum level time
    end else if (hold_r != 5'h00) begin
      hold_r <= hold_r - 5'h01;
    end
  end
  assign dig_trig_in       = (hold_r != 5'h00);
  assign cnt_in            = {4{div_r[1]}};
  assign dio_in            = pins;
  assign ext_scan_clock_in = 1'b0;
  assign hw_mon            = 11'h000;
  assign adc_valid         = 1'b0;
  assign adc_chan          = 5'h00;
  assign adc_data          = 16'h0000;
endmodule : acq_far_side

// ==== verification/acq_trigger_sequencer_test.sv ====
// Purpose: self-checking bench for the acquisition trigger sequencer
// Assumes: APB master with one-cycle slave answer, pacer period of one step
// Notes: scans are timed against the 1250-cycle or, with rate10, 2500-cycle entry spacing
`timescale 1ns/100ps
module acq_trigger_sequencer_test;
  logic           pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0, prdata;
  logic [23:0]    pins = 24'h0, dio_in;
  logic           pready, pslverr, ext_clk_w, dig_w, adc_v, running;
  logic [10:0]    hw_mon;
  logic [4:0]     adc_chan;
  logic [15:0]    adc_data;
  logic [3:0]     cnt_in;
  logic [4:0]     mon_w;
  logic [23:0]    dout_w, oe_w;
  acq_pkg::scan_s scan_w;
  int             fail_count = 0, n_tests = 0;
  always #2 pclk = ~pclk;
  acq_far_side far (.pclk(pclk), .fire(fire), .pins(pins), .ext_scan_clock_in(ext_clk_w), .dig_trig_in(dig_w),
    .hw_mon(hw_mon), .adc_valid(adc_v), .adc_chan(adc_chan), .adc_data(adc_data), .cnt_in(cnt_in), .dio_in(dio_in));
  acq_trigger_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_scan_clock_in(ext_clk_w), .dig_trig_in(dig_w), .hw_mon(hw_mon), .mon_chan(mon_w), .adc_valid(adc_v),
    .adc_chan(adc_chan), .adc_data(adc_data), .cnt_in(cnt_in), .dio_in(dio_in), .dio_out(dout_w), .dio_oe_n(oe_w),
    .scan(scan_w), .running(running));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      fail_count++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic wait_scan(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (scan_w.valid !== 1'b1 && n < 3000);
  endtask : wait_scan
  task automatic wait_run(input int lim);
    int n;
    n = 0;
    while (running !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_run
  task automatic stop_clear();
    logic [31:0] q;
    logic        e;
    wr(acq_pkg::A_CMD, 32'h2);
    rd(acq_pkg::A_STAT, q, e);
    check({30'h0, q[1:0]}, 32'h3);
    check(32'(running), 32'h0);
    wr(acq_pkg::A_STAT, 32'h3);
    rd(acq_pkg::A_STAT, q, e);
    check(q, 32'h0);
  endtask : stop_clear
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rd(acq_pkg::A_PACER, q, e);
    check(q, acq_pkg::PACER_RST);
    rd(acq_pkg::A_STAT, q, e);
    check(q, 32'h0);
    rd(8'h3c, q, e);
    check(32'(e), 32'h1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_scan(input logic r10);
    acq_pkg::entry_s e0, e1;
    acq_pkg::ctrl_s  c;
    logic [31:0]     q;
    logic            e;
    int              n;
    e0 = '{kind: acq_pkg::K_ANA, bip: 1'b1, gain: 3'h2, chan: 5'h05};
    e1 = '{kind: acq_pkg::K_DIG, bip: 1'b0, gain: 3'h0, chan: 5'h01};
    c = '0;
    c.rate10 = r10; c.start_src = acq_pkg::T_SOFT; c.stop_src = acq_pkg::T_SOFT;
    pins <= 24'h003c00;
    wr(acq_pkg::A_SEQLEN, 32'h1);
    wr(acq_pkg::A_SEQADR, 32'h0);
    wr(acq_pkg::A_SEQDAT, 32'(e0));
    wr(acq_pkg::A_SEQDAT, 32'(e1));
    wr(acq_pkg::A_CTRL, 32'(c));
    wr(acq_pkg::A_CMD, 32'h1);
    wr(acq_pkg::A_CMD, 32'h2);
    rd(acq_pkg::A_STAT, q, e);
    check({30'h0, q[1:0]}, 32'h1);
    check(32'(running), 32'h1);
    wait_scan(n);
    check(32'(scan_w.idx), 32'h0);
    check(32'(scan_w.ent), 32'(e0));
    wait_scan(n);
    check(32'(n), r10 ? 32'd2500 : 32'd1250);
    check(32'(scan_w.idx), 32'h1);
    check(32'(scan_w.ent), 32'(e1));
    check(32'(scan_w.data), 32'h3c);
    wait_scan(n);
    check(32'(scan_w.idx), 32'h0);
    stop_clear();
    $display("t_scan done");
  endtask : t_scan
  task automatic t_dig();
    acq_pkg::ctrl_s c;
    c = '0;
    c.start_src = acq_pkg::T_DIG; c.stop_src = acq_pkg::T_SOFT;
    wr(acq_pkg::A_CTRL, 32'(c));
    wr(acq_pkg::A_CMD, 32'h1);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    wait_run(1250);
    check(32'(running), 32'h1);
    stop_clear();
    $display("t_dig done");
  endtask : t_dig
  task automatic t_pat();
    acq_pkg::ctrl_s c;
    c = '0;
    c.start_src = acq_pkg::T_PAT; c.start_cmp = acq_pkg::C_EQ; c.stop_src = acq_pkg::T_SOFT;
    pins <= 24'h0000a3;
    wr(acq_pkg::A_PAT, 32'h000000a5);
    wr(acq_pkg::A_PMASK, 32'h0);
    wr(acq_pkg::A_CTRL, 32'(c));
    wr(acq_pkg::A_CMD, 32'h1);
    wait_run(2600);
    check(32'(running), 32'h0);
    // Masking the low nibble makes a3 match a5
    wr(acq_pkg::A_PMASK, 32'h0000000f);
    wait_run(2600);
    check(32'(running), 32'h1);
    stop_clear();
    $display("t_pat done");
  endtask : t_pat
  task automatic t_dio();
    acq_pkg::ctrl_s c;
    logic [31:0]    q;
    logic           e;
    c = '0;
    c.port_dir = 3'h2; c.clr_rd = 4'h1;
    wr(acq_pkg::A_DIO, 32'h00123456);
    wr(acq_pkg::A_TCH, 32'h00000907);
    wr(acq_pkg::A_CTRL, 32'(c));
    // First read clears counter 0, so the second sees at most two new edges
    rd(acq_pkg::A_CTR0, q, e);
    check({8'h0, dout_w}, 32'h00123456);
    check({8'h0, oe_w}, 32'h00ff00ff);
    check(32'(mon_w), 32'h7);
    rd(acq_pkg::A_CTR0, q, e);
    check(32'(q[15:0] <= 16'h2), 32'h1);
    $display("t_dio done");
  endtask : t_dio
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #(4 * 40000);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_scan(1'b0);
    t_scan(1'b1);
    t_dig();
    t_pat();
    t_dio();
    end_of_test();
  end
endmodule : acq_trigger_sequencer_test
